//--- hw/crt_aux_pkg.sv
// holds constants, field layouts and carrier types of the auxiliary timing block
// assumes one clock domain and an indexed host port driven by the bus front end

package crt_aux_pkg;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SERRATION = 8'h39;
  localparam logic [7:0] IDX_HSYNC_DOTS = 8'h3a;
  localparam logic [7:0] IDX_HW_TEST_TWO = 8'h3b;
  localparam logic [7:0] IDX_BLANK_SELECT = 8'h3c;
  localparam logic [7:0] IDX_SCRATCH_A = 8'h3d;
  localparam logic [7:0] IDX_SCRATCH_B = 8'h3e;
  localparam logic [7:0] IDX_SCRATCH_C = 8'h3f;
  localparam logic [7:0] IDX_EXP_CTRL = 8'h9e;

  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SERR_LSB = 0;
  localparam int SERR_W = 6;
  localparam int DOTS_LSB = 0;
  localparam int SDLY_LSB = 3;
  localparam int BSS_BIT = 5;
  localparam int LCO_BIT = 4;
  localparam int FE_BIT = 7;
  localparam int FORCE_BIT = 6;
  localparam int BANK_BIT = 5;
  localparam int DDA_SRC_BIT = 4;
  localparam int VOFF_SRC_BIT = 3;
  localparam int VEXP_EN_BIT = 2;
  localparam int VCEN_EN_BIT = 1;
  localparam int HCEN_EN_BIT = 0;
  localparam int TBL_LSB = 1;

  // ----------------------------------------------------------------
  // counts and codes
  // ----------------------------------------------------------------
  localparam int SERR_UNIT_CLKS = 4;
  localparam int STD_CHAR_DOTS = 8;
  localparam int HTOTAL_EXTRA = 5;
  localparam int SYNC_DLY_MAX = 5;
  localparam logic [2:0] DOTS_MIN = 3'h2;
  localparam logic [4:0] CHAR_H_LIMIT = 5'h0f;
  localparam logic [2:0] TBL_ALL_ON = 3'h7;
  localparam int VOFF_TBL_SHIFT = 2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic idx_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic [9:0] dda_const;
    logic [9:0] dda_table;
    logic table_hit;
    logic [5:0] voff_reg;
    logic [5:0] voff_table;
    logic [6:0] hoff_reg;
  } exp_src_t;

  typedef enum logic [1:0] {
    SERR_IDLE = 2'b01,
    SERR_PULSE = 2'b10
  } serr_state_t;

endpackage

//--- hw/sync_delay_line.sv
// holds the selectable delay line for the horizontal sync
// assumes the input is on the same clock; output is registered
`timescale 1ns/10ps

module sync_delay_line
  import crt_aux_pkg::*;
#(
  parameter int DEPTH = 5
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic sig_in,
  input wire logic [2:0] sel,
  output logic sig_out_r
);

  logic [DEPTH:0] taps_r;
  logic tap_sel;

  // values beyond the depth fall back to no delay
  assign tap_sel = (int'(sel) <= DEPTH) ? taps_r[sel] : taps_r[0];

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      taps_r <= '0;
      sig_out_r <= 1'b0;
    end else if (ce) begin
      taps_r <= {taps_r[DEPTH-1:0], sig_in};
      sig_out_r <= tap_sel;
    end
  end

endmodule

//--- hw/crt_aux_timing_expansion_ctrl.sv
// holds the auxiliary timing, blanking and expansion control block
// assumes every timing input comes from crtc logic on sys_clk, the video clock
`timescale 1ns/10ps

module crt_aux_timing_expansion_ctrl
  import crt_aux_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input host_req_t host_req,
  output logic [7:0] rdata_r,
  output logic rd_hit_r,
  input wire logic serration_start,
  output logic serration_r,
  input wire logic hsync_in,
  output logic hsync_out_r,
  input wire logic [7:0] htotal,
  output logic char_tick_r,
  output logic line_end_r,
  input wire logic disp_en,
  input wire logic timing_blank,
  output logic blank_r,
  output logic border_en_r,
  input wire logic [9:0] line_cmp_value,
  input wire logic [9:0] scan_line,
  output logic line_cmp_hit_r,
  input wire logic text_mode,
  input wire logic [4:0] char_height,
  output logic font_repeat_row_r,
  output logic font_insert_bg_r,
  input wire logic vsync_in,
  input wire logic ten_dot_expand,
  input wire logic twelve_dot_expand,
  input wire logic panel_select_reg,
  output logic timing_secondary_r,
  output logic host_secondary_r,
  input exp_src_t exp_src,
  output logic vexp_active_r,
  output logic [9:0] dda_value_r,
  output logic vcenter_active_r,
  output logic [7:0] voffset_r,
  output logic hcenter_active_r,
  output logic [6:0] hshift_r
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] idx_r;
  logic [7:0] serr_reg_r;
  logic [7:0] dly_reg_r;
  logic [7:0] bsel_reg_r;
  logic [7:0] scr_a_r;
  logic [7:0] scr_b_r;
  logic [7:0] scr_c_r;
  logic [7:0] ctrl_r;

  logic wr_serr;
  logic wr_dly;
  logic wr_bsel;
  logic wr_scr_a;
  logic wr_scr_b;
  logic wr_scr_c;
  logic wr_ctrl;
  logic rd_known;
  logic [7:0] rd_mux;

  assign wr_serr = host_req.data_wr && (idx_r == IDX_SERRATION);
  assign wr_dly = host_req.data_wr && (idx_r == IDX_HSYNC_DOTS);
  assign wr_bsel = host_req.data_wr && (idx_r == IDX_BLANK_SELECT);
  assign wr_scr_a = host_req.data_wr && (idx_r == IDX_SCRATCH_A);
  assign wr_scr_b = host_req.data_wr && (idx_r == IDX_SCRATCH_B);
  assign wr_scr_c = host_req.data_wr && (idx_r == IDX_SCRATCH_C);
  assign wr_ctrl = host_req.data_wr && (idx_r == IDX_EXP_CTRL);

  // reserved bits of the serration and delay registers read back as zero
  assign rd_mux =
    (idx_r == IDX_SERRATION) ? {2'h0, serr_reg_r[5:0]} :
    (idx_r == IDX_HSYNC_DOTS) ? {2'h0, dly_reg_r[5:0]} :
    (idx_r == IDX_BLANK_SELECT) ? bsel_reg_r :
    (idx_r == IDX_SCRATCH_A) ? scr_a_r :
    (idx_r == IDX_SCRATCH_B) ? scr_b_r :
    (idx_r == IDX_SCRATCH_C) ? scr_c_r :
    (idx_r == IDX_EXP_CTRL) ? ctrl_r :
    8'h00;

  assign rd_known = (idx_r == IDX_SERRATION) || (idx_r == IDX_HSYNC_DOTS) ||
    (idx_r == IDX_HW_TEST_TWO) || (idx_r == IDX_BLANK_SELECT) ||
    (idx_r == IDX_SCRATCH_A) || (idx_r == IDX_SCRATCH_B) ||
    (idx_r == IDX_SCRATCH_C) || (idx_r == IDX_EXP_CTRL);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      idx_r <= REG_RESET;
      serr_reg_r <= REG_RESET;
      dly_reg_r <= REG_RESET;
      bsel_reg_r <= REG_RESET;
      scr_a_r <= REG_RESET;
      scr_b_r <= REG_RESET;
      scr_c_r <= REG_RESET;
      ctrl_r <= REG_RESET;
    end else if (ce) begin
      if (host_req.idx_wr) idx_r <= host_req.wdata;
      if (wr_serr) serr_reg_r <= host_req.wdata;
      if (wr_dly) dly_reg_r <= host_req.wdata;
      if (wr_bsel) bsel_reg_r <= host_req.wdata;
      if (wr_scr_a) scr_a_r <= host_req.wdata;
      if (wr_scr_b) scr_b_r <= host_req.wdata;
      if (wr_scr_c) scr_c_r <= host_req.wdata;
      if (wr_ctrl) ctrl_r <= host_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
      rd_hit_r <= 1'b0;
    end else if (ce) begin
      rdata_r <= host_req.data_rd ? rd_mux : 8'h00;
      rd_hit_r <= host_req.data_rd && rd_known;
    end
  end

  // ----------------------------------------------------------------
  // serration pulse
  // ----------------------------------------------------------------
  serr_state_t serr_state_r;
  serr_state_t serr_state_nxt;
  logic [7:0] serr_cnt_r;
  logic [7:0] serr_cnt_nxt;
  logic [7:0] serr_len;

  assign serr_len = 8'(serr_reg_r[SERR_LSB +: SERR_W] * SERR_UNIT_CLKS);

  always_comb begin
    serr_state_nxt = serr_state_r;
    serr_cnt_nxt = serr_cnt_r;
    unique case (serr_state_r)
      SERR_IDLE: begin
        if (serration_start && (serr_len != 8'h00)) begin
          serr_state_nxt = SERR_PULSE;
          serr_cnt_nxt = serr_len - 8'h01;
        end
      end
      SERR_PULSE: begin
        if (serr_cnt_r == 8'h00) begin
          serr_state_nxt = SERR_IDLE;
        end else begin
          serr_cnt_nxt = serr_cnt_r - 8'h01;
        end
      end
      default: begin
        serr_state_nxt = SERR_IDLE;
        serr_cnt_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      serr_state_r <= SERR_IDLE;
      serr_cnt_r <= 8'h00;
      serration_r <= 1'b0;
    end else if (ce) begin
      serr_state_r <= serr_state_nxt;
      serr_cnt_r <= serr_cnt_nxt;
      serration_r <= (serr_state_nxt == SERR_PULSE);
    end
  end

  // ----------------------------------------------------------------
  // hsync delay
  // ----------------------------------------------------------------
  sync_delay_line #(
    .DEPTH(SYNC_DLY_MAX)
  ) u_hsync_dly (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .sig_in(hsync_in),
    .sel(dly_reg_r[SDLY_LSB +: 3]),
    .sig_out_r(hsync_out_r)
  );

  // ----------------------------------------------------------------
  // character clock
  // ----------------------------------------------------------------
  logic [2:0] dot_cnt_r;
  logic [8:0] char_cnt_r;
  logic [8:0] last_char;
  logic [2:0] dot_sel;
  logic short_ok;
  logic is_last;
  logic [2:0] dot_last;
  logic char_done;

  assign last_char = 9'({1'b0, htotal} + 9'(HTOTAL_EXTRA) - 9'h001);
  assign dot_sel = dly_reg_r[DOTS_LSB +: 3];
  assign short_ok = (dot_sel >= DOTS_MIN);
  assign is_last = (char_cnt_r >= last_char);
  // only the last character of the line takes the short count
  assign dot_last = (is_last && short_ok) ? (dot_sel - 3'h1) :
    3'(STD_CHAR_DOTS - 1);
  assign char_done = (dot_cnt_r == dot_last);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dot_cnt_r <= 3'h0;
      char_cnt_r <= 9'h000;
      char_tick_r <= 1'b0;
      line_end_r <= 1'b0;
    end else if (ce) begin
      dot_cnt_r <= char_done ? 3'h0 : dot_cnt_r + 3'h1;
      if (char_done) begin
        char_cnt_r <= is_last ? 9'h000 : char_cnt_r + 9'h001;
      end
      char_tick_r <= char_done;
      line_end_r <= char_done && is_last;
    end
  end

  // ----------------------------------------------------------------
  // blank and line compare
  // ----------------------------------------------------------------
  logic blank_source_select;
  logic blank_nxt;
  logic border_nxt;
  logic [9:0] cmp_eff;

  assign blank_source_select = bsel_reg_r[BSS_BIT];
  assign blank_nxt = blank_source_select ? timing_blank : ~disp_en;
  assign border_nxt = blank_source_select && !timing_blank && !disp_en;
  assign cmp_eff = bsel_reg_r[LCO_BIT] ? {2'h0, line_cmp_value[7:0]} :
    line_cmp_value;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      blank_r <= 1'b0;
      border_en_r <= 1'b0;
      line_cmp_hit_r <= 1'b0;
    end else if (ce) begin
      blank_r <= blank_nxt;
      border_en_r <= border_nxt;
      line_cmp_hit_r <= (scan_line == cmp_eff);
    end
  end

  // ----------------------------------------------------------------
  // font expansion
  // ----------------------------------------------------------------
  logic vexp_en;
  logic font_active;

  assign vexp_en = ctrl_r[VEXP_EN_BIT];
  assign font_active = !ctrl_r[DDA_SRC_BIT] && text_mode && vexp_en &&
    (char_height < CHAR_H_LIMIT);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      font_repeat_row_r <= 1'b0;
      font_insert_bg_r <= 1'b0;
    end else if (ce) begin
      font_repeat_row_r <= font_active && !ctrl_r[FE_BIT];
      font_insert_bg_r <= font_active && ctrl_r[FE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // horizontal shadow set selection
  // ----------------------------------------------------------------
  logic vsync_d_r;
  logic sec_latched_r;
  logic vsync_rise;
  logic sec_want;

  assign vsync_rise = vsync_in && !vsync_d_r;
  assign sec_want = ten_dot_expand || twelve_dot_expand || panel_select_reg;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      vsync_d_r <= 1'b0;
      sec_latched_r <= 1'b0;
      timing_secondary_r <= 1'b0;
      host_secondary_r <= 1'b0;
    end else if (ce) begin
      vsync_d_r <= vsync_in;
      if (vsync_rise) sec_latched_r <= sec_want;
      timing_secondary_r <= ctrl_r[FORCE_BIT] ||
        (vsync_rise ? sec_want : sec_latched_r);
      host_secondary_r <= ctrl_r[BANK_BIT];
    end
  end

  // ----------------------------------------------------------------
  // vertical expansion and centering
  // ----------------------------------------------------------------
  logic tbl_ok;
  logic dda_tbl;
  logic voff_tbl;
  logic vcen_en;
  logic hcen_en;
  logic [9:0] dda_nxt;
  logic [7:0] voff_nxt;

  assign vcen_en = ctrl_r[VCEN_EN_BIT];
  assign hcen_en = ctrl_r[HCEN_EN_BIT];
  assign tbl_ok = (ctrl_r[TBL_LSB +: 3] == TBL_ALL_ON) && exp_src.table_hit;
  assign dda_tbl = ctrl_r[DDA_SRC_BIT] && tbl_ok;
  assign voff_tbl = ctrl_r[VOFF_SRC_BIT] && tbl_ok;
  assign dda_nxt = !vexp_en ? 10'h000 :
    (dda_tbl ? exp_src.dda_table : exp_src.dda_const);
  assign voff_nxt = !vcen_en ? 8'h00 :
    (voff_tbl ? 8'({exp_src.voff_table, 2'h0}) : {2'h0, exp_src.voff_reg});

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      vexp_active_r <= 1'b0;
      dda_value_r <= 10'h000;
      vcenter_active_r <= 1'b0;
      voffset_r <= 8'h00;
      hcenter_active_r <= 1'b0;
      hshift_r <= 7'h00;
    end else if (ce) begin
      vexp_active_r <= vexp_en;
      dda_value_r <= dda_nxt;
      vcenter_active_r <= vcen_en;
      voffset_r <= voff_nxt;
      hcenter_active_r <= hcen_en;
      hshift_r <= hcen_en ? exp_src.hoff_reg : 7'h00;
    end
  end

endmodule

//--- tb/crt_aux_checker_assertions.sv
// port-level checker of the auxiliary timing block
// assumes the block's top ports, one clock and a synchronous active-low reset
`timescale 1ns/10ps

module crt_aux_checker
  import crt_aux_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input host_req_t host_req,
  input wire logic [7:0] rdata_r,
  input wire logic rd_hit_r,
  input wire logic serration_start,
  input wire logic serration_r,
  input wire logic char_tick_r,
  input wire logic line_end_r,
  input wire logic disp_en,
  input wire logic timing_blank,
  input wire logic border_en_r,
  input wire logic [9:0] line_cmp_value,
  input wire logic [9:0] scan_line,
  input wire logic line_cmp_hit_r,
  input wire logic text_mode,
  input wire logic [4:0] char_height,
  input wire logic font_repeat_row_r,
  input wire logic font_insert_bg_r,
  input exp_src_t exp_src,
  input wire logic vexp_active_r,
  input wire logic [9:0] dda_value_r,
  input wire logic vcenter_active_r,
  input wire logic [7:0] voffset_r,
  input wire logic hcenter_active_r,
  input wire logic [6:0] hshift_r
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  wire logic [7:0] sl_lo = scan_line[7:0];
  wire logic [7:0] lc_lo = line_cmp_value[7:0];
  wire logic [6:0] hoff = exp_src.hoff_reg;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  AST_RESET_ZERO: assert property ($rose(nrst) |-> rdata_r == 8'h00 && !rd_hit_r && !serration_r)
    else $error("outputs not zero after reset");
  AST_RD_IDLE: assert property (ce && !host_req.data_rd |=> rdata_r == 8'h00 && !rd_hit_r)
    else $error("read data without a read");
  AST_SERR_MIN: assert property ($rose(serration_r) |-> serration_r [*4])
    else $error("serration shorter than one unit");
  AST_SERR_CAUSE: assert property ($rose(serration_r) |-> $past(serration_start))
    else $error("serration without start");
  AST_LINE_END: assert property (line_end_r |-> char_tick_r)
    else $error("line end off a character tick");
  AST_BORDER: assert property (border_en_r |-> !$past(timing_blank) && !$past(disp_en))
    else $error("border during blank or display");
  AST_LCMP: assert property (line_cmp_hit_r |-> $past(sl_lo) == $past(lc_lo))
    else $error("line compare hit on low bit mismatch");
  AST_FONT: assert property (font_repeat_row_r || font_insert_bg_r |->
    $past(text_mode) && $past(char_height) < 5'h0f && !(font_repeat_row_r && font_insert_bg_r))
    else $error("font expansion out of its conditions");
  AST_DDA_OFF: assert property (!vexp_active_r && !$past(vexp_active_r) |-> dda_value_r == 10'h000)
    else $error("dda value while expansion off");
  AST_VOFF_OFF: assert property (!vcenter_active_r && !$past(vcenter_active_r) |-> voffset_r == 8'h00)
    else $error("vertical offset while centering off");
  AST_HSHIFT: assert property (hcenter_active_r && $past(hcenter_active_r) |-> hshift_r == $past(hoff))
    else $error("horizontal shift not the offset");
endmodule

bind crt_aux_timing_expansion_ctrl crt_aux_checker i_crt_aux_checker (.*);

//--- tb/tv_encoder_model.sv
// far-side model: palette dac and tv encoder measuring serration pulses
// assumes serration is registered on sys_clk
`timescale 1ns/10ps

module tv_encoder_model (
  input wire logic sys_clk,
  input wire logic serration,
  output logic [7:0] serr_len
);
  logic [7:0] run_r = 8'h00;
  logic [7:0] len_r = 8'h00;

  assign serr_len = len_r;

  // length of the last whole pulse, in video clocks
  always @(posedge sys_clk) begin
    if (serration) begin
      run_r <= run_r + 8'h01;
    end else if (run_r != 8'h00) begin
      len_r <= run_r;
      run_r <= 8'h00;
    end
  end
endmodule

//--- tb/tb_top.sv
// self-checking bench of the auxiliary timing block
// assumes the bound checker and the tv encoder model beside the block
`timescale 1ns/10ps

module tb_top;
  import crt_aux_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, ce = 1'b1;
  host_req_t host_req = '0;
  exp_src_t exp_src = '{10'h155, 10'h2aa, 1'b0, 6'h15, 6'h2b, 7'h55};
  logic serration_start = 1'b0, hsync_in = 1'b0, disp_en = 1'b0, timing_blank = 1'b0;
  logic text_mode = 1'b0, vsync_in = 1'b0, ten_dot_expand = 1'b0, twelve_dot_expand = 1'b0;
  logic panel_select_reg = 1'b0;
  logic [7:0] htotal = 8'h02;
  logic [9:0] line_cmp_value = 10'h305, scan_line = 10'h005;
  logic [4:0] char_height = 5'h0e;
  logic [7:0] rdata_r, voffset_r, serr_len;
  logic rd_hit_r, serration_r, hsync_out_r, char_tick_r, line_end_r, blank_r, border_en_r;
  logic line_cmp_hit_r, font_repeat_row_r, font_insert_bg_r, timing_secondary_r;
  logic host_secondary_r, vexp_active_r, vcenter_active_r, hcenter_active_r;
  logic [9:0] dda_value_r;
  logic [6:0] hshift_r;
  int err_total = 0, n_tests = 0, cyc = 0;

  crt_aux_timing_expansion_ctrl i_crt_aux_timing_expansion_ctrl (.*);
  tv_encoder_model i_tv_encoder_model (.sys_clk(sys_clk), .serration(serration_r),
    .serr_len(serr_len));

  always #50 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("BAD %0t timeout", $time);
      give_verdict();
    end
  end

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [7:0] idx, input logic [7:0] d);
    @(posedge sys_clk) host_req <= '{1'b1, 1'b0, 1'b0, idx};
    @(posedge sys_clk) host_req <= '{1'b0, 1'b1, 1'b0, d};
    @(posedge sys_clk) host_req <= '0;
  endtask

  task automatic get(input logic [7:0] idx, input logic [7:0] exp, input logic hit);
    @(posedge sys_clk) host_req <= '{1'b1, 1'b0, 1'b0, idx};
    @(posedge sys_clk) host_req <= '{1'b0, 1'b0, 1'b1, 8'h00};
    @(posedge sys_clk) host_req <= '0;
    #1 chk(10'(rdata_r), 10'(exp));
    chk(10'(rd_hit_r), 10'(hit));
  endtask

  task automatic settle(output int k, input int which);
    k = 0;
    do begin
      @(posedge sys_clk);
      #1 k++;
    end while ((which ? hsync_out_r : line_end_r) !== 1'b1 && k < 200);
  endtask

  task automatic vsync_edge();
    @(posedge sys_clk) vsync_in <= 1'b1;
    repeat (3) @(posedge sys_clk);
    vsync_in <= 1'b0;
    #1;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] idx [8] = '{8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h9e};
    foreach (idx[i]) get(idx[i], 8'h00, 1'b1);
    get(8'h40, 8'h00, 1'b0);
    put(IDX_SCRATCH_A, 8'ha5);
    put(IDX_SCRATCH_B, 8'h5a);
    put(IDX_SCRATCH_C, 8'hff);
    put(IDX_HW_TEST_TWO, 8'h77);
    put(8'h40, 8'h12);
    put(IDX_SERRATION, 8'hff);
    get(IDX_SCRATCH_A, 8'ha5, 1'b1);
    get(IDX_SCRATCH_B, 8'h5a, 1'b1);
    get(IDX_SCRATCH_C, 8'hff, 1'b1);
    get(IDX_HW_TEST_TWO, 8'h00, 1'b1);
    get(8'h40, 8'h00, 1'b0);
    get(IDX_SERRATION, 8'h3f, 1'b1);
  endtask

  task automatic t_serr();
    logic [7:0] f [2] = '{8'h01, 8'h3f};
    foreach (f[i]) begin
      put(IDX_SERRATION, f[i]);
      @(posedge sys_clk) serration_start <= 1'b1;
      @(posedge sys_clk) serration_start <= 1'b0;
      repeat (260) @(posedge sys_clk);
      chk(10'(serr_len), 10'(f[i] * SERR_UNIT_CLKS));
    end
  endtask

  task automatic t_hsync_char();
    int k;
    for (int n = 0; n < 8; n++) begin
      put(IDX_HSYNC_DOTS, 8'(n << 3));
      @(posedge sys_clk) hsync_in <= 1'b1;
      settle(k, 1);
      chk(10'(k), 10'(n > SYNC_DLY_MAX ? 2 : 2 + n));
      @(posedge sys_clk) hsync_in <= 1'b0;
      repeat (10) @(posedge sys_clk);
    end
    for (int d = 0; d < 8; d++) begin
      put(IDX_HSYNC_DOTS, 8'(d));
      settle(k, 0);
      settle(k, 0);
      chk(10'(k), 10'((htotal + HTOTAL_EXTRA - 1) * STD_CHAR_DOTS + (d < 2 ? 8 : d)));
    end
  endtask

  task automatic blank_case(input logic [7:0] sel, input logic de, input logic tbk,
    input logic [2:0] exp);
    put(IDX_BLANK_SELECT, sel);
    @(posedge sys_clk) disp_en <= de;
    timing_blank <= tbk;
    repeat (2) @(posedge sys_clk);
    #1 chk(10'({blank_r, border_en_r, line_cmp_hit_r}), 10'(exp));
  endtask

  task automatic exp_case(input logic [7:0] ctl, input logic hit);
    logic tbl;
    tbl = ctl[3:1] == 3'b111 && hit;
    put(IDX_EXP_CTRL, ctl);
    exp_src.table_hit <= hit;
    repeat (3) @(posedge sys_clk);
    #1 chk(dda_value_r, !ctl[2] ? 10'h0 : ctl[4] && tbl ? exp_src.dda_table : exp_src.dda_const);
    chk(10'(voffset_r), !ctl[1] ? 10'h0 : ctl[3] && tbl ? 10'({exp_src.voff_table, 2'b00}) : 10'(exp_src.voff_reg));
    chk(10'(hshift_r), ctl[0] ? 10'(exp_src.hoff_reg) : 10'h0);
    chk(10'({host_secondary_r, vexp_active_r, vcenter_active_r, hcenter_active_r}), 10'({ctl[5], ctl[2:0]}));
  endtask

  task automatic font_case(input logic tm, input logic [7:0] ctl, input logic [4:0] h,
    input logic [1:0] exp);
    put(IDX_EXP_CTRL, ctl);
    @(posedge sys_clk) char_height <= h;
    text_mode <= tm;
    repeat (3) @(posedge sys_clk);
    #1 chk(10'({font_repeat_row_r, font_insert_bg_r}), 10'(exp));
  endtask

  task automatic t_shadow();
    put(IDX_EXP_CTRL, 8'h40);
    repeat (2) @(posedge sys_clk);
    #1 chk(10'(timing_secondary_r), 10'h1);
    put(IDX_EXP_CTRL, 8'h00);
    for (int s = 0; s < 3; s++) begin
      @(posedge sys_clk) {panel_select_reg, twelve_dot_expand, ten_dot_expand} <= 3'(1 << s);
      repeat (4) @(posedge sys_clk);
      #1 chk(10'(timing_secondary_r), 10'h0);
      vsync_edge();
      chk(10'(timing_secondary_r), 10'h1);
      @(posedge sys_clk) {panel_select_reg, twelve_dot_expand, ten_dot_expand} <= 3'b000;
      vsync_edge();
      chk(10'(timing_secondary_r), 10'h0);
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs();
    t_serr();
    t_hsync_char();
    blank_case(8'h00, 1'b0, 1'b0, 3'b100);
    blank_case(8'h00, 1'b1, 1'b1, 3'b000);
    blank_case(8'h20, 1'b0, 1'b1, 3'b100);
    blank_case(8'h20, 1'b0, 1'b0, 3'b010);
    blank_case(8'h30, 1'b1, 1'b0, 3'b001);
    blank_case(8'h10, 1'b0, 1'b0, 3'b101);
    for (int i = 0; i < 7; i++) exp_case(8'(i * 5 + 8'h07 * (i == 3)), 1'b1);
    exp_case(8'h1f, 1'b1);
    exp_case(8'h1f, 1'b0);
    exp_case(8'h3e, 1'b1);
    exp_case(8'h17, 1'b1);
    font_case(1'b1, 8'h04, 5'h0e, 2'b10);
    font_case(1'b1, 8'h84, 5'h0e, 2'b01);
    font_case(1'b1, 8'h84, 5'h0f, 2'b00);
    font_case(1'b1, 8'h94, 5'h0e, 2'b00);
    font_case(1'b0, 8'h84, 5'h0e, 2'b00);
    t_shadow();
    give_verdict();
  end
endmodule
